// ---- hdl/dsc_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: Definitions only
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// ----------------------------------------------------------------------
// Register file addresses
// ----------------------------------------------------------------------
`define DSC_ADDR_VA 3'h0
`define DSC_ADDR_VB 3'h1
`define DSC_ADDR_VC 3'h2
`define DSC_ADDR_MEM 3'h3
`define DSC_ADDR_RSVD 3'h4
`define DSC_ADDR_DIV 3'h5
`define DSC_ADDR_CTL 3'h6
// ----------------------------------------------------------------------
// Field positions in the 24-bit frame; data word is bits 20:0
// ----------------------------------------------------------------------
`define DSC_CTL_HOLD_SRC 20
`define DSC_CTL_TO_EXT 19
`define DSC_CTL_CONV_RST 18
`define DSC_CTL_DUTY 17
`define DSC_CTL_PAD_TTL 16
`define DSC_CTL_PRESC_LO 13
`define DSC_DIV_HI 20
`define DSC_DIV_LO 18
`define DSC_ADDR_HI 23
`define DSC_ADDR_LO 21
// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define DSC_DIV_RESET 3'h1
`define DSC_CTL_RESET 8'h00
`define DSC_UNLOCK_MIN 3'h5
`define DSC_FRAME_BITS 5'h18
`define DSC_INIT_REF_EDGES 5'h10
`define DSC_CLK_NS 10
`define DSC_WD_NS 2000000
`define DSC_SEL_TO_NS 5000000
`define DSC_MEM_NOM_NS 30
`endif

// ---- hdl/dsc_pkg.sv ----
// Purpose: Shared types of the synthesizer control block
// Assumes: Nothing
// Notes: Constants live in dsc_map.svh
package dsc_pkg;
  typedef struct packed {
    logic [3:0] index;
    logic [6:0] p_cnt;
    logic [2:0] div_sel;
    logic [6:0] q_cnt;
  } dsc_freq_word_t;
  typedef struct packed {
    logic hold_src;
    logic to_ext;
    logic conv_rst;
    logic duty;
    logic pad_ttl;
    logic [2:0] prescale;
  } dsc_ctrl_t;
  typedef enum logic [1:0] {S_UNLOCK, S_START, S_BITS, S_STOP} dsc_ser_st_t;
  typedef enum logic [1:0] {T_IDLE, T_WAIT, T_HOLD} dsc_tmr_st_t;
endpackage

// ---- hdl/dsc_init_rom.sv ----
// Purpose: Power-up table of frequency words, registered read
// Assumes: Address is {init_hi, init_lo, word}; word 3 is the memory word
// Notes: Encodings are parameters, frequencies listed per row
`timescale 1ns/1ps
`default_nettype none
module dsc_init_rom #(
  // Rows 00: 32.500/25.175/28.322/28.322, 01: 40.000/..., 10: 50.350/
  // 110/135/165, 11: 56.644/110/135/185 MHz; encodings set at integration
  parameter logic [16*21-1:0] CONTENT = '0
) (
  input wire logic clk,
  input wire logic [3:0] addr,
  output logic [20:0] data
);
  always_ff @(posedge clk) begin
    data <= CONTENT[addr*21 +: 21];
  end
endmodule // dsc_init_rom
`default_nettype wire

// ---- hdl/dsc_load_div.sv ----
// Purpose: Load clock divider from the sampled video oscillator level
// Assumes: Oscillator well below half the system clock
// Notes: Counts oscillator half periods
`timescale 1ns/1ps
`default_nettype none
module dsc_load_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vco_lvl,
  input wire logic [2:0] div_code,
  input wire logic load_enable,
  output logic prim,
  output logic div2,
  output logic div4,
  output logic gated
);
  logic vco_prev_q, en_q, prim_prev_q;
  // Five bits: divide by eight needs sixteen half periods
  logic [4:0] cnt_q, per, low, nxt;
  wire vco_edge = vco_lvl ^ vco_prev_q;
  wire prim_rise = prim & ~prim_prev_q;
  // Half periods and low halves per code
  assign per = div_code[2] ? (div_code[1] ? 5'h04 : 5'h02) :
               (div_code[1:0] == 2'h0) ? 5'h06 :
               (div_code[1:0] == 2'h1) ? 5'h08 :
               (div_code[1:0] == 2'h2) ? 5'h0A : 5'h10;
  assign low = {1'b0, per[4:1]} - ((div_code[2:0] == 3'h0 ||
               div_code[2:0] == 3'h2) ? 5'h01 : 5'h00);
  assign nxt = (cnt_q + 5'h01 >= per) ? 5'h00 : cnt_q + 5'h01;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_prev_q <= 1'b0;
      cnt_q <= 5'h00;
      prim <= 1'b0;
      prim_prev_q <= 1'b0;
      div2 <= 1'b0;
      div4 <= 1'b0;
      en_q <= 1'b0;
      gated <= 1'b0;
    end else begin
      vco_prev_q <= vco_lvl;
      prim_prev_q <= prim;
      if (vco_edge) begin
        cnt_q <= nxt;
        prim <= nxt >= low;
      end
      if (prim_rise) begin
        div2 <= ~div2;
        if (div2) begin
          div4 <= ~div4;
        end
        en_q <= load_enable;
      end
      gated <= prim & en_q;
    end
  end
endmodule // dsc_load_div
`default_nettype wire

// ---- hdl/dsc_top.sv ----
// Purpose: Serial programming, register file and clock selection
// Assumes: Pins and oscillator levels synchronous to clk
// Notes: Oscillators enter as sampled levels
//
// Contract
// - Address 0-2 video words, 3 memory, 5 divisor, 6 control, 4 reserved.
// - Video out three-state when disabled; 00 word a, 01 b, sel1 word c.
// - Memory out three-state when disabled, else runs from memory word.
// - Serial download keeps video source unless active register written.
// - Select change applies after one timeout, then hold clock one more.
// - Stop bit writing memory or active video word forces hold interval.
// - Video hold clock is reference by default, memory clock when bit set; memory hold uses reference.
// - Timeout counts memory oscillator edges, doubled by extension bit.
// - Converter reset sequence runs only on the first set of its bit.
// - Duty bit requests 1 ns shorter high time, default none.
// - Pad level bit defaults ECL; TTL keeps video pad three-stated.
// - Control word holds one prescale bit per video word.
// - Load clock is video oscillator divided; also /2, /4 and gated.
// - Divisor codes 10X /1, 11X /2, 000 /3, 001 /4, 010 /5, 011 /8.
// - Divisor resets to the divide-by-four code.
// - Unlock needs five or more data-high clock rises then one data-low.
// - Watchdog restarts per edge; 2 ms idle rearms and drops frame.
// - Select pins reach decode only after watchdog timeout.
// - Power-up loads video and memory words from table by init pins.
// - Initialization runs on first 16 reference clock rises.
// - Frame is start, 21 data, 3 address, stop; stop loads and rearms.
// - Data bit sampled on rise with complement on preceding fall.
// - Start, encoding or stop fault drives error low till unlock.
// - Word fields index 20:17, P 16:10, divider 9:7, Q 6:0.
`include "dsc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dsc_top import dsc_pkg::*; #(
  parameter int WD_CYC = (`DSC_WD_NS) / (`DSC_CLK_NS),
  parameter int TO_TICKS = (`DSC_SEL_TO_NS) / (`DSC_MEM_NOM_NS),
  parameter int CONV_CYC = 16,
  parameter logic [16*21-1:0] INIT_CONTENT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sel0_serial_clk,
  input wire logic sel1_serial_data,
  input wire logic out_enable,
  input wire logic ref_clk_in,
  input wire logic video_vco,
  input wire logic mem_vco,
  input wire logic power_init_sel_lo,
  input wire logic power_init_sel_hi,
  input wire logic load_enable,
  output logic video_clk_out,
  output logic video_clk_oe,
  output logic mem_clk_out,
  output logic mem_clk_oe,
  output logic prog_error_n,
  output dsc_freq_word_t video_cfg,
  output dsc_freq_word_t mem_cfg,
  output logic video_prescale,
  output logic duty_adjust,
  output logic conv_reset,
  output logic load_clk_primary,
  output logic load_clk_div2,
  output logic load_clk_div4,
  output logic load_clk_gated,
  output logic init_done
);
  initial begin
    if (WD_CYC < 2 || WD_CYC >= (1 << 20) || TO_TICKS < 1 ||
        TO_TICKS >= (1 << 19) || CONV_CYC < 1 || CONV_CYC > 255) begin
      $error("dsc_top: parameter out of range");
    end
  end
  // ----------------------------------------------------------------------
  // Reset release and edge detection
  // ----------------------------------------------------------------------
  logic rst_a_q, rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n <= rst_a_q;
    end
  end
  logic sck_p_q, sdt_p_q, ref_p_q, mem_p_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_p_q <= 1'b0;
      sdt_p_q <= 1'b0;
      ref_p_q <= 1'b0;
      mem_p_q <= 1'b0;
    end else begin
      sck_p_q <= sel0_serial_clk;
      sdt_p_q <= sel1_serial_data;
      ref_p_q <= ref_clk_in;
      mem_p_q <= mem_vco;
    end
  end
  wire sck_rise = sel0_serial_clk & ~sck_p_q;
  wire sck_fall = ~sel0_serial_clk & sck_p_q;
  wire pin_edge = (sel0_serial_clk ^ sck_p_q) | (sel1_serial_data ^ sdt_p_q);
  wire ref_rise = ref_clk_in & ~ref_p_q;
  wire mem_tick = mem_vco & ~mem_p_q;
  // ----------------------------------------------------------------------
  // Power-on initialization
  // ----------------------------------------------------------------------
  logic [1:0] init_sel_q, init_idx_q;
  logic init_cap_q, init_wr_q;
  logic [4:0] init_cnt_q;
  logic [20:0] rom_data;
  wire init_active = init_cnt_q < `DSC_INIT_REF_EDGES;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_sel_q <= 2'h0;
      init_cap_q <= 1'b0;
      init_cnt_q <= 5'h0;
      init_wr_q <= 1'b0;
      init_idx_q <= 2'h0;
    end else begin
      init_cap_q <= 1'b1;
      if (!init_cap_q) begin
        init_sel_q <= {power_init_sel_hi, power_init_sel_lo};
      end
      init_wr_q <= init_cap_q && init_active && ref_rise &&
                   init_cnt_q < 5'h4;
      init_idx_q <= init_cnt_q[1:0];
      if (init_cap_q && init_active && ref_rise) begin
        init_cnt_q <= init_cnt_q + 5'h1;
      end
    end
  end
  assign init_done = ~init_active;
  dsc_init_rom #(.CONTENT(INIT_CONTENT)) u_rom (
    .clk(clk),
    .addr({init_sel_q, init_cnt_q[1:0]}),
    .data(rom_data)
  );
  // ----------------------------------------------------------------------
  // Watchdog and serial decoder
  // ----------------------------------------------------------------------
  logic [19:0] wd_q;
  wire wd_idle = wd_q == 20'(WD_CYC);
  wire wd_expire = wd_q == 20'(WD_CYC - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_q <= 20'(WD_CYC);
    end else if (pin_edge) begin
      wd_q <= 20'h0;
    end else if (!wd_idle) begin
      wd_q <= wd_q + 20'h1;
    end
  end
  dsc_ser_st_t st_q, st_d;
  logic [2:0] ones_q;
  logic [4:0] bits_q;
  logic [23:0] sr_q;
  logic comp_q, err_n_q;
  wire enc_bad = sck_rise && (sel1_serial_data == comp_q);
  wire stop_ok = sel1_serial_data && comp_q;
  wire load_fire = st_q == S_STOP && sck_rise && stop_ok && !wd_expire;
  wire unlock_done = st_q == S_UNLOCK && sck_rise && !sel1_serial_data &&
                     ones_q >= `DSC_UNLOCK_MIN;
  wire frame_err = !wd_expire && ((st_q == S_START && sck_rise &&
                   sel1_serial_data) || (st_q == S_BITS && enc_bad) ||
                   (st_q == S_STOP && sck_rise && !stop_ok));
  wire [2:0] ld_addr = sr_q[`DSC_ADDR_HI:`DSC_ADDR_LO];
  wire [20:0] ld_data = sr_q[20:0];
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_UNLOCK: if (unlock_done) st_d = S_START;
      S_START: if (sck_rise) st_d = sel1_serial_data ? S_UNLOCK : S_BITS;
      S_BITS: begin
        if (enc_bad) begin
          st_d = S_UNLOCK;
        end else if (sck_rise && bits_q == `DSC_FRAME_BITS - 5'h1) begin
          st_d = S_STOP;
        end
      end
      S_STOP: if (sck_rise) st_d = S_UNLOCK;
      default: st_d = S_UNLOCK;
    endcase
    if (wd_expire || !init_done) begin
      st_d = S_UNLOCK;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_UNLOCK;
      ones_q <= 3'h0;
      bits_q <= 5'h0;
      sr_q <= 24'h0;
      comp_q <= 1'b0;
      err_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      if (sck_fall) begin
        comp_q <= sel1_serial_data;
      end
      if (st_q != S_UNLOCK || wd_expire) begin
        ones_q <= 3'h0;
      end else if (sck_rise) begin
        ones_q <= !sel1_serial_data ? 3'h0 :
                  (ones_q < `DSC_UNLOCK_MIN) ? ones_q + 3'h1 : ones_q;
      end
      if (st_q == S_START) begin
        bits_q <= 5'h0;
      end else if (st_q == S_BITS && sck_rise && !enc_bad) begin
        bits_q <= bits_q + 5'h1;
        sr_q <= {sel1_serial_data, sr_q[23:1]};
      end
      if (unlock_done) begin
        err_n_q <= 1'b1;
      end else if (frame_err) begin
        err_n_q <= 1'b0;
      end
    end
  end
  assign prog_error_n = err_n_q;
  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [20:0] vword_q [3];
  logic [20:0] mword_q;
  logic [2:0] div_q;
  dsc_ctrl_t ctl_q;
  logic conv_done_q;
  logic [7:0] conv_cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mword_q <= 21'h0;
      div_q <= `DSC_DIV_RESET;
      ctl_q <= `DSC_CTL_RESET;
    end else if (init_wr_q) begin
      if (init_idx_q == 2'h3) begin
        mword_q <= rom_data;
      end
    end else if (load_fire) begin
      case (ld_addr)
        `DSC_ADDR_MEM: mword_q <= ld_data;
        `DSC_ADDR_DIV: div_q <= ld_data[`DSC_DIV_HI:`DSC_DIV_LO];
        `DSC_ADDR_CTL: ctl_q <= ld_data[20:13];
        default: ;
      endcase
    end
  end
  for (genvar i = 0; i < 3; i++) begin : g_vword
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        vword_q[i] <= 21'h0;
      end else if (init_wr_q && init_idx_q == 2'(i)) begin
        vword_q[i] <= rom_data;
      end else if (load_fire && ld_addr == 3'(i)) begin
        vword_q[i] <= ld_data;
      end
    end
  end
  // ----------------------------------------------------------------------
  // Converter reset one-shot
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_done_q <= 1'b0;
      conv_cnt_q <= 8'h0;
    end else if (ctl_q.conv_rst && !conv_done_q) begin
      conv_done_q <= 1'b1;
      conv_cnt_q <= 8'(CONV_CYC);
    end else if (conv_cnt_q != 8'h0) begin
      conv_cnt_q <= conv_cnt_q - 8'h1;
    end
  end
  assign conv_reset = conv_cnt_q != 8'h0;
  assign duty_adjust = ctl_q.duty;
  // ----------------------------------------------------------------------
  // Selection and hold timers
  // ----------------------------------------------------------------------
  logic [1:0] sel_seen_q, sel_act_q;
  dsc_tmr_st_t vt_q, mt_q;
  logic [18:0] vcnt_q, mcnt_q;
  wire [18:0] to_lim = ctl_q.to_ext ? 19'(2 * TO_TICKS) : 19'(TO_TICKS);
  wire [1:0] act_idx = sel_act_q[1] ? 2'h2 : {1'b0, sel_act_q[0]};
  // An edge out of idle is a frame start, never a selection
  wire sel_new = init_done && wd_idle && !pin_edge &&
                 {sel1_serial_data, sel0_serial_clk} != sel_seen_q;
  wire v_wr_act = load_fire && ld_addr == {1'b0, act_idx};
  wire m_wr = load_fire && ld_addr == `DSC_ADDR_MEM;
  wire vt_end = mem_tick && vcnt_q + 19'h1 >= to_lim;
  wire mt_end = mem_tick && mcnt_q + 19'h1 >= to_lim;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_seen_q <= 2'h0;
      sel_act_q <= 2'h0;
      vt_q <= T_IDLE;
      vcnt_q <= 19'h0;
    end else begin
      if (sel_new) begin
        sel_seen_q <= {sel1_serial_data, sel0_serial_clk};
        vt_q <= T_WAIT;
        vcnt_q <= 19'h0;
      end else if (v_wr_act) begin
        vt_q <= T_HOLD;
        vcnt_q <= 19'h0;
      end else begin
        case (vt_q)
          T_WAIT: begin
            vcnt_q <= vt_end ? 19'h0 : vcnt_q + {18'h0, mem_tick};
            if (vt_end) begin
              sel_act_q <= sel_seen_q;
              vt_q <= T_HOLD;
            end
          end
          T_HOLD: begin
            vcnt_q <= vt_end ? 19'h0 : vcnt_q + {18'h0, mem_tick};
            if (vt_end) vt_q <= T_IDLE;
          end
          default: vt_q <= T_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mt_q <= T_IDLE;
      mcnt_q <= 19'h0;
    end else if (m_wr) begin
      mt_q <= T_HOLD;
      mcnt_q <= 19'h0;
    end else if (mt_q == T_HOLD) begin
      mcnt_q <= mt_end ? 19'h0 : mcnt_q + {18'h0, mem_tick};
      if (mt_end) mt_q <= T_IDLE;
    end else begin
      mt_q <= T_IDLE;
    end
  end
  // ----------------------------------------------------------------------
  // Glitch-free output muxes
  // ----------------------------------------------------------------------
  // Source only swaps while both clocks are low, so no runt pulse escapes
  logic vsrc_q, msrc_q;
  wire hold_lvl = ctl_q.hold_src ? mem_vco : ref_clk_in;
  wire v_want = vt_q == T_HOLD;
  wire m_want = mt_q == T_HOLD;
  wire v_cur = vsrc_q ? hold_lvl : video_vco;
  wire m_cur = msrc_q ? ref_clk_in : mem_vco;
  wire v_swap = vsrc_q != v_want && !video_vco && !hold_lvl;
  wire m_swap = msrc_q != m_want && !mem_vco && !ref_clk_in;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vsrc_q <= 1'b0;
      msrc_q <= 1'b0;
      video_clk_out <= 1'b0;
      mem_clk_out <= 1'b0;
    end else begin
      if (v_swap) vsrc_q <= v_want;
      if (m_swap) msrc_q <= m_want;
      video_clk_out <= v_cur;
      mem_clk_out <= m_cur;
    end
  end
  assign video_clk_oe = out_enable && !ctl_q.pad_ttl;
  assign mem_clk_oe = out_enable;
  assign video_cfg = dsc_freq_word_t'(vword_q[act_idx]);
  assign mem_cfg = dsc_freq_word_t'(mword_q);
  assign video_prescale = ctl_q.prescale[2 - act_idx];
  dsc_load_div u_ldiv (
    .clk(clk),
    .rst_n(rst_n),
    .vco_lvl(video_vco),
    .div_code(div_q),
    .load_enable(load_enable),
    .prim(load_clk_primary),
    .div2(load_clk_div2),
    .div4(load_clk_div4),
    .gated(load_clk_gated)
  );
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_err_hold;
    @(posedge clk) disable iff (!rst_n)
    !prog_error_n && !unlock_done |=> !prog_error_n;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error released");
  property p_vid_hiz;
    @(posedge clk) disable iff (!rst_n)
    !out_enable || ctl_q.pad_ttl |-> !video_clk_oe;
  endproperty
  a_vid_hiz: assert property (p_vid_hiz) else $error("video driven");
  property p_mem_hiz;
    @(posedge clk) disable iff (!rst_n) mem_clk_oe == out_enable;
  endproperty
  a_mem_hiz: assert property (p_mem_hiz) else $error("memory oe wrong");
  property p_stop_rearm;
    @(posedge clk) disable iff (!rst_n) load_fire |=> st_q == S_UNLOCK;
  endproperty
  a_stop_rearm: assert property (p_stop_rearm) else $error("no rearm");
  property p_wd_rearm;
    @(posedge clk) disable iff (!rst_n)
    wd_expire |=> st_q == S_UNLOCK && ones_q == 3'h0;
  endproperty
  a_wd_rearm: assert property (p_wd_rearm) else $error("watchdog");
  property p_rsvd;
    @(posedge clk) disable iff (!rst_n)
    load_fire && ld_addr == `DSC_ADDR_RSVD && !init_wr_q |=>
      $stable(mword_q) && $stable(div_q) && $stable(ctl_q) &&
      $stable(vword_q[0]) && $stable(vword_q[1]) && $stable(vword_q[2]) &&
      prog_error_n == $past(prog_error_n);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved write");
  property p_conv_once;
    @(posedge clk) disable iff (!rst_n)
    conv_done_q && !conv_reset |=> !conv_reset [*8];
  endproperty
  a_conv_once: assert property (p_conv_once) else $error("conv again");
  property p_mem_hold;
    @(posedge clk) disable iff (!rst_n) m_wr |=> mt_q == T_HOLD;
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("no mem hold");
  property p_sel_frozen;
    @(posedge clk) disable iff (!rst_n)
    !wd_idle |=> $stable(sel_seen_q);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen) else $error("sel leak");
endmodule // dsc_top
`default_nettype wire

// ---- bench/dsc_host_model.sv ----
// Purpose: Graphics controller side of the select/serial pins
// Assumes: Pins sampled by the block on clk
// Notes: Levels held 6 clk each, well inside the watchdog
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
  input wire logic clk,
  output logic sel0_serial_clk,
  output logic sel1_serial_data
);
  initial begin
    sel0_serial_clk = 1'b0;
    sel1_serial_data = 1'b0;
  end
  // Data settles before the clock moves, so no edge sees a race
  task automatic put(input logic c, input logic d);
    sel1_serial_data = d;
    repeat (3) @(negedge clk);
    sel0_serial_clk = c;
    repeat (3) @(negedge clk);
  endtask
  // -----------------------------------------------------------------
  // Frame
  // -----------------------------------------------------------------
  task automatic frame(input logic [20:0] d, input logic [2:0] a,
                       input logic bad);
    logic [23:0] w;
    w = {a, d};
    repeat (5) begin
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
    end
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    for (int i = 0; i < 24; i++) begin
      put(1'b0, (bad && i == 3) ? w[i] : ~w[i]);
      put(1'b1, w[i]);
    end
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b0, 1'b0);
  endtask
endmodule // dsc_host_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Self-checking bench of the synthesizer control block
// Assumes: Short watchdog and timeout parameters
// Notes: Oscillators are slow counters off clk
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsc_pkg::*;
  logic clk, resetn, s_clk, s_dat, vco_v, vco_m, ref_c;
  logic v_out, v_oe, m_out, m_oe, err_n, presc, duty, conv, init_done;
  logic l_p, l_2, l_4, l_g;
  logic oe = 1'b1, ld_en = 1'b1;
  dsc_freq_word_t video_cfg, mem_cfg;
  wire [5:0] mon = {l_p, l_2, l_4, l_g, v_out, m_out};
  // Table rows 8..11 belong to init pins 10
  localparam logic [335:0] INIT = {84'h0, 21'h0ABCDE, 21'h0,
    21'h054321, 21'h012345, 168'h0};
  logic [3:0] osc_q = 4'h0;
  int fails = 0, n_compared = 0, cyc = 0, conv_hi = 0;
  assign vco_v = osc_q[0];
  assign ref_c = osc_q[1];
  assign vco_m = osc_q[2];
  dsc_top #(.WD_CYC(50), .TO_TICKS(8), .INIT_CONTENT(INIT)) u_dut (
    .clk(clk),
    .resetn(resetn), .sel0_serial_clk(s_clk), .sel1_serial_data(s_dat),
    .out_enable(oe), .ref_clk_in(ref_c), .video_vco(vco_v),
    .mem_vco(vco_m), .power_init_sel_lo(1'b0), .power_init_sel_hi(1'b1),
    .load_enable(ld_en), .video_clk_out(v_out), .video_clk_oe(v_oe),
    .mem_clk_out(m_out), .mem_clk_oe(m_oe), .prog_error_n(err_n),
    .video_cfg(video_cfg), .mem_cfg(mem_cfg), .video_prescale(presc),
    .duty_adjust(duty), .conv_reset(conv), .load_clk_primary(l_p),
    .load_clk_div2(l_2), .load_clk_div4(l_4), .load_clk_gated(l_g),
    .init_done(init_done));
  dsc_host_model u_host (.clk(clk), .sel0_serial_clk(s_clk),
    .sel1_serial_data(s_dat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Timeout ceiling well above the whole run of about 4000 cycles
  always @(negedge clk) begin
    osc_q <= osc_q + 4'h1;
    cyc <= cyc + 1;
    if (conv === 1'b1) conv_hi <= conv_hi + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  task automatic check(input string nm, input logic [20:0] seen,
                       input logic [20:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  // Rises of one monitored output over 64 cycles
  task automatic rises(input int b, output logic [20:0] n);
    logic pv;
    n = 21'h0;
    pv = mon[b];
    repeat (64) begin
      @(negedge clk);
      if (mon[b] && !pv) n = n + 21'h1;
      pv = mon[b];
    end
  endtask
  task automatic t_reset();
    logic [20:0] n;
    for (int i = 0; i < 500 && init_done !== 1'b1; i++) @(negedge clk);
    check("init_done", 21'(init_done), 21'h1);
    check("err_n", 21'(err_n), 21'h1);
    check("mem_oe", 21'(m_oe), 21'h1);
    check("video_oe", 21'(v_oe), 21'h1);
    check("duty", 21'(duty), 21'h0);
    check("video_cfg", video_cfg, 21'h012345);
    check("mem_cfg", mem_cfg, 21'h0ABCDE);
    oe = 1'b0;
    @(negedge clk);
    check("video_oe", 21'(v_oe), 21'h0);
    check("mem_oe", 21'(m_oe), 21'h0);
    oe = 1'b1;
    rises(5, n);
    check("lda", n, 21'h8);
    rises(4, n);
    check("lda2", n, 21'h4);
    rises(3, n);
    check("lda4", n, 21'h2);
    rises(2, n);
    check("ldc", n, 21'h8);
    rises(1, n);
    check("video_out", n, 21'h20);
    rises(0, n);
    check("mem_out", n, 21'h8);
    $display("test reset done");
  endtask
  task automatic t_mem();
    u_host.frame(21'h15A5C3, 3'h3, 1'b0);
    check("mem_cfg", mem_cfg, 21'h15A5C3);
    check("q_cnt", 21'(mem_cfg.q_cnt), 21'h43);
    check("index", 21'(mem_cfg.index), 21'hA);
    u_host.frame(21'h0F0F0F, 3'h4, 1'b0);
    check("mem_cfg", mem_cfg, 21'h15A5C3);
    check("err_n", 21'(err_n), 21'h1);
    $display("test mem done");
  endtask
  task automatic t_ctl();
    u_host.frame(21'h070000, 3'h6, 1'b0);
    repeat (30) @(negedge clk);
    check("duty", 21'(duty), 21'h1);
    check("video_oe", 21'(v_oe), 21'h0);
    check("conv_hi", 21'(conv_hi), 21'h10);
    // Clear, then set again: the sequence must not rerun
    u_host.frame(21'h000000, 3'h6, 1'b0);
    u_host.frame(21'h044000, 3'h6, 1'b0);
    repeat (30) @(negedge clk);
    check("conv_hi", 21'(conv_hi), 21'h10);
    check("video_oe", 21'(v_oe), 21'h1);
    $display("test ctl done");
  endtask
  task automatic t_err();
    u_host.frame(21'h000123, 3'h0, 1'b1);
    check("err_n", 21'(err_n), 21'h0);
    u_host.frame(21'h0C0000, 3'h5, 1'b0);
    check("err_n", 21'(err_n), 21'h1);
    $display("test err done");
  endtask
  task automatic t_load();
    logic [20:0] n;
    repeat (40) @(negedge clk);
    rises(5, n);
    check("lda", n, 21'h4);
    rises(4, n);
    check("lda2", n, 21'h2);
    rises(3, n);
    check("lda4", n, 21'h1);
    ld_en = 1'b0;
    repeat (40) @(negedge clk);
    rises(2, n);
    check("ldc", n, 21'h0);
    ld_en = 1'b1;
    $display("test load done");
  endtask
  task automatic t_sel();
    u_host.put(1'b1, 1'b0);
    repeat (54) @(negedge clk);
    check("video_cfg", video_cfg, 21'h012345);
    check("presc", 21'(presc), 21'h0);
    repeat (120) @(negedge clk);
    check("video_cfg", video_cfg, 21'h054321);
    check("presc", 21'(presc), 21'h1);
    $display("test select done");
  endtask
  initial begin
    resetn = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_mem();
    t_ctl();
    t_err();
    t_load();
    t_sel();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
